/* hw/ocps_pkg.sv */
// package for the overcurrent pick-up and status stage
// assumes one 200 MHz clock and a plain word-wide register port
package ocps_pkg;

  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned STEP_MS        = 5;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * STEP_MS;
  localparam int unsigned MAG_W          = 16;
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned RATIO_SCALE    = 100;
  localparam int unsigned RELEASE_PCT    = 97;
  localparam int unsigned MAX_TIME_STEPS = 360_000;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_THRESH   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DELAY    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COND     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EXP_TIME = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_REMAIN   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RATIO    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h20;

  // field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_IDMT_BIT = 3;
  localparam int unsigned COND_LSB      = 0;
  localparam int unsigned PHASE_LSB     = 4;
  localparam int unsigned BEHAV_LSB     = 8;
  localparam int unsigned IRQ_W         = 3;

  // reset values
  localparam logic [MAG_W-1:0] THRESH_RST = 16'h0078;
  localparam logic [MAG_W-1:0] DELAY_RST  = 16'h0014;
  localparam logic [IRQ_W-1:0] MASK_RST   = 3'h0;

  typedef enum logic [1:0] {
    COND_NORMAL  = 2'h0,
    COND_START   = 2'h1,
    COND_TRIP    = 2'h2,
    COND_BLOCKED = 2'h3
  } ocps_cond_type;

  typedef enum logic [2:0] {
    LN_ON           = 3'h1,
    LN_BLOCKED      = 3'h2,
    LN_TEST         = 3'h3,
    LN_TEST_BLOCKED = 3'h4,
    LN_OFF          = 3'h5
  } ocps_ln_mode_type;

  // divider sequencer, gray along idle -> run -> done
  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00,
    DIV_RUN  = 2'b01,
    DIV_DONE = 2'b11
  } ocps_div_state_type;

  typedef struct packed {
    logic [2:0][MAG_W-1:0] mag;
  } ocps_phase_mag_type;

  typedef struct packed {
    logic start;
    logic trip;
    logic blocked;
  } ocps_stage_type;

endpackage : ocps_pkg

/* hw/ocps_pickup.sv */
// one phase pick-up comparator with fixed release level
// assumes magnitude and threshold in hundredths of nominal current
`timescale 1ns/10ps
module ocps_pickup
  import ocps_pkg::*;
#(
  parameter int unsigned W = ocps_pkg::MAG_W
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_enable,
  input  wire logic [W-1:0] i_measured_magnitude,
  input  wire logic [W-1:0] i_pickup_threshold,
  output logic              o_pickup
);

  logic [W+7:0] mag_scaled;
  logic [W+7:0] rel_level;
  logic         above;
  logic         below;

  assign mag_scaled = (W+8)'(i_measured_magnitude) * (W+8)'(RATIO_SCALE);
  assign rel_level  = (W+8)'(i_pickup_threshold) * (W+8)'(RELEASE_PCT);
  assign above      = i_measured_magnitude > i_pickup_threshold; // R02
  assign below      = mag_scaled < rel_level; // R04

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pickup <= 1'b0;
    end else if (!i_enable) begin
      o_pickup <= 1'b0;
    end else if (above) begin
      o_pickup <= 1'b1;
    end else if (below) begin
      o_pickup <= 1'b0;
    end // R13
  end

endmodule : ocps_pickup

/* hw/ocps_divider.sv */
// unsigned restoring divider, one quotient bit per cycle
// latches operands at start, so they may change while busy; zero divisor gives all ones
`timescale 1ns/10ps
module ocps_divider
  import ocps_pkg::*;
#(
  parameter int unsigned W = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_num,
  input  wire logic [W-1:0] i_den,
  output logic [W-1:0]      o_quo,
  output logic              o_done
);

  ocps_div_state_type state_q;
  logic [W-1:0]       rem_q;
  logic [W-1:0]       quo_q;
  logic [W-1:0]       den_q;
  logic [5:0]         cnt_q;
  logic [W:0]         trial;

  assign trial = {rem_q, quo_q[W-1]} - {1'b0, den_q};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= DIV_IDLE;
      rem_q   <= '0;
      quo_q   <= '0;
      den_q   <= '0;
      cnt_q   <= '0;
      o_quo   <= '0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state_q)
        DIV_IDLE: begin
          if (i_start) begin
            rem_q   <= '0;
            quo_q   <= i_num;
            den_q   <= i_den;
            cnt_q   <= 6'(W);
            state_q <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          if (trial[W]) begin
            rem_q <= {rem_q[W-2:0], quo_q[W-1]};
            quo_q <= {quo_q[W-2:0], 1'b0};
          end else begin
            rem_q <= trial[W-1:0];
            quo_q <= {quo_q[W-2:0], 1'b1};
          end
          cnt_q <= cnt_q - 6'h01;
          if (cnt_q == 6'h01) begin
            state_q <= DIV_DONE;
          end
        end
        DIV_DONE: begin
          o_quo   <= (den_q == '0) ? '1 : quo_q;
          o_done  <= 1'b1;
          state_q <= DIV_IDLE;
        end
        default: begin
          state_q <= DIV_IDLE;
        end
      endcase
    end
  end

endmodule : ocps_divider

/* hw/ocps_stage.sv */
// three-phase overcurrent pick-up stage with status reporting
// assumes magnitudes in hundredths of nominal current, synchronous to i_clk
//
// Functional notes
// R01: compare each phase against threshold continuously
// R02: pick-up when any phase exceeds threshold
// R03: one threshold shared by all phases
// R04: release below fixed 97 percent of threshold
// R05: threshold in hundredths of nominal current
// R06: start only when picked up and unblocked
// R07: overall code normal, start, trip, blocked
// R08: per-phase start and trip codes 0 to 14
// R09: report behaviour mode 1 to 5
// R10: expected operating time, 5 ms, follows current
// R11: time remaining to trip in 5 ms steps
// R12: highest phase current to threshold, hundredths
// R13: hold phase pick-up inside hysteresis band
`timescale 1ns/10ps
module ocps_stage
  import ocps_pkg::*;
#(
  parameter int unsigned TICKS = ocps_pkg::TICK_CYCLES
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire ocps_pkg::ocps_phase_mag_type i_phase,
  input  wire logic                       i_phase_overcurrent_block,
  input  wire logic [ocps_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [ocps_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic [ocps_pkg::DATA_W-1:0]     o_rdata,
  output ocps_pkg::ocps_stage_type        o_stage,
  output logic                            o_irq
);

  import ocps_pkg::*;

  localparam int unsigned TW = $clog2(TICKS + 1);

  // per-phase code from active mask and trip flag
  function automatic logic [3:0] phase_code(input logic [2:0] m, input logic trip);
    logic [3:0] base;
    base = 4'h0;
    case (m)
      3'b001:  base = trip ? 4'h4 : 4'h1;
      3'b010:  base = trip ? 4'h5 : 4'h2;
      3'b100:  base = trip ? 4'h6 : 4'h3;
      3'b011:  base = trip ? 4'hB : 4'h7;
      3'b110:  base = trip ? 4'hC : 4'h8;
      3'b101:  base = trip ? 4'hD : 4'h9;
      3'b111:  base = trip ? 4'hE : 4'hA;
      default: base = 4'h0;
    endcase
    return base;
  endfunction : phase_code

  function automatic logic mode_valid(input logic [2:0] m);
    return (m >= 3'(LN_ON)) && (m <= 3'(LN_OFF));
  endfunction : mode_valid

  // software registers
  ocps_ln_mode_type mode_q;
  logic             idmt_q;
  logic [MAG_W-1:0] thresh_q;
  logic [MAG_W-1:0] delay_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;

  // stage state
  logic [2:0]       pickup;
  logic             pickup_any;
  logic             blk;
  logic             stage_en;
  logic             start_q;
  logic             trip_q;
  logic             blocked_q;
  logic [2:0]       phase_act_q;
  ocps_cond_type    cond_q;
  logic [3:0]       phase_cond_q;
  logic [TW-1:0]    tick_cnt_q;
  logic             tick;
  logic [31:0]      elapsed_q;
  logic [31:0]      expected_q;
  logic [31:0]      remain_q;
  logic [MAG_W-1:0] max_mag;
  logic [31:0]      ratio_q;
  logic [31:0]      ratio_quo;
  logic             ratio_done;
  logic [31:0]      idmt_quo;
  logic             idmt_done;
  logic [31:0]      exp_raw;
  logic [IRQ_W-1:0] irq_event;
  logic             wr_stat;

  assign stage_en = mode_q != LN_OFF;
  assign blk      = i_phase_overcurrent_block || (mode_q == LN_BLOCKED) ||
                    (mode_q == LN_TEST_BLOCKED);

  // per-phase comparators against the single threshold
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_phase
      ocps_pickup #(
        .W (MAG_W)
      ) u_pickup (
        .i_clk                (i_clk),
        .i_rst_n              (i_rst_n),
        .i_enable             (stage_en),
        .i_measured_magnitude (i_phase.mag[gi]),
        .i_pickup_threshold   (thresh_q),
        .o_pickup             (pickup[gi])
      ); // R01 R03
    end
  endgenerate

  assign pickup_any = |pickup; // R02

  always_comb begin
    max_mag = i_phase.mag[0];
    if (i_phase.mag[1] > max_mag) begin
      max_mag = i_phase.mag[1];
    end
    if (i_phase.mag[2] > max_mag) begin
      max_mag = i_phase.mag[2];
    end
  end

  // ratio of highest phase to threshold, in hundredths
  ocps_divider #(
    .W (32)
  ) u_ratio_div (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_start (1'b1),
    .i_num   (32'(max_mag) * 32'(RATIO_SCALE)),
    .i_den   (32'(thresh_q)),
    .o_quo   (ratio_quo),
    .o_done  (ratio_done)
  ); // R12

  // inverse time: delay scaled down by the present ratio
  ocps_divider #(
    .W (32)
  ) u_idmt_div (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_start (1'b1),
    .i_num   (32'(delay_q) * 32'(RATIO_SCALE)),
    .i_den   (ratio_q),
    .o_quo   (idmt_quo),
    .o_done  (idmt_done)
  ); // R10

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ratio_q <= 32'h0000_0000;
    end else if (ratio_done) begin
      ratio_q <= ratio_quo; // R12
    end
  end

  assign exp_raw = (idmt_q && ratio_q > 32'(RATIO_SCALE)) ? idmt_quo : 32'(delay_q);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      expected_q <= 32'h0000_0000;
    end else if (!idmt_q || idmt_done) begin
      expected_q <= (exp_raw > 32'(MAX_TIME_STEPS)) ? 32'(MAX_TIME_STEPS) : exp_raw; // R10
    end
  end

  // start and blocked outputs, per-phase active mask
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_q     <= 1'b0;
      blocked_q   <= 1'b0;
      phase_act_q <= 3'h0;
    end else begin
      start_q     <= pickup_any && !blk; // R06
      blocked_q   <= pickup_any && blk;
      phase_act_q <= blk ? 3'h0 : pickup;
    end
  end

  // 5 ms time base, runs only while started
  assign tick = tick_cnt_q == TW'(TICKS - 1);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_q <= '0;
    end else if (!start_q || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      elapsed_q <= 32'h0000_0000;
    end else if (!start_q) begin
      elapsed_q <= 32'h0000_0000;
    end else if (tick && elapsed_q < expected_q) begin
      elapsed_q <= elapsed_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trip_q   <= 1'b0;
      remain_q <= 32'h0000_0000;
    end else begin
      trip_q   <= start_q && (elapsed_q >= expected_q);
      remain_q <= (start_q && elapsed_q < expected_q) ? expected_q - elapsed_q
                                                      : 32'h0000_0000; // R11
    end
  end

  // condition codes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cond_q       <= COND_NORMAL;
      phase_cond_q <= 4'h0;
    end else begin
      if (blocked_q) begin
        cond_q <= COND_BLOCKED;
      end else if (trip_q) begin
        cond_q <= COND_TRIP;
      end else if (start_q) begin
        cond_q <= COND_START;
      end else begin
        cond_q <= COND_NORMAL;
      end // R07
      phase_cond_q <= phase_code(phase_act_q, trip_q); // R08
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_stage <= '0;
    end else begin
      o_stage.start   <= start_q;
      o_stage.trip    <= trip_q;
      o_stage.blocked <= blocked_q;
    end
  end

  // software control registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q   <= LN_ON;
      idmt_q   <= 1'b0;
      thresh_q <= THRESH_RST;
      delay_q  <= DELAY_RST;
    end else if (i_wr) begin
      if (i_addr == OFS_CTRL) begin
        if (mode_valid(i_wdata[CTRL_MODE_LSB+:3])) begin
          mode_q <= ocps_ln_mode_type'(i_wdata[CTRL_MODE_LSB+:3]); // R09
        end
        idmt_q <= i_wdata[CTRL_IDMT_BIT];
      end else if (i_addr == OFS_THRESH) begin
        thresh_q <= i_wdata[MAG_W-1:0]; // R05
      end else if (i_addr == OFS_DELAY) begin
        delay_q <= i_wdata[MAG_W-1:0];
      end
    end
  end

  // sticky events: start, trip, blocked rising edges
  assign irq_event = {blocked_q & ~o_stage.blocked, trip_q & ~o_stage.trip,
                      start_q & ~o_stage.start};
  assign wr_stat   = i_wr && (i_addr == OFS_IRQ_STAT);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_q <= '0;
      irq_mask_q <= MASK_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? i_wdata[IRQ_W-1:0] : '0)) | irq_event;
      if (i_wr && i_addr == OFS_IRQ_MASK) begin
        irq_mask_q <= i_wdata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= 32'h0000_0000;
      if (i_addr == OFS_CTRL) begin
        o_rdata[CTRL_MODE_LSB+:3] <= mode_q;
        o_rdata[CTRL_IDMT_BIT]    <= idmt_q;
      end else if (i_addr == OFS_THRESH) begin
        o_rdata[MAG_W-1:0] <= thresh_q;
      end else if (i_addr == OFS_DELAY) begin
        o_rdata[MAG_W-1:0] <= delay_q;
      end else if (i_addr == OFS_COND) begin
        o_rdata[COND_LSB+:2]  <= cond_q;
        o_rdata[PHASE_LSB+:4] <= phase_cond_q;
        o_rdata[BEHAV_LSB+:3] <= mode_q; // R09
      end else if (i_addr == OFS_EXP_TIME) begin
        o_rdata <= expected_q;
      end else if (i_addr == OFS_REMAIN) begin
        o_rdata <= remain_q;
      end else if (i_addr == OFS_RATIO) begin
        o_rdata <= ratio_q;
      end else if (i_addr == OFS_IRQ_STAT) begin
        o_rdata[IRQ_W-1:0] <= irq_stat_q;
      end else if (i_addr == OFS_IRQ_MASK) begin
        o_rdata[IRQ_W-1:0] <= irq_mask_q;
      end
    end
  end

endmodule : ocps_stage

/* bench/ocps_stage_monitor.sv */
// checker for the overcurrent pick-up stage, bound to its ports
// assumes threshold, mode and mask change only through bus writes
`timescale 1ns/10ps
module ocps_stage_monitor
  import ocps_pkg::*;
#(
  parameter int unsigned TICKS = 10
) (
  input wire logic                           i_clk,
  input wire logic                           i_rst_n,
  input wire ocps_pkg::ocps_phase_mag_type   i_phase,
  input wire logic                           i_phase_overcurrent_block,
  input wire logic [ocps_pkg::ADDR_W-1:0]    i_addr,
  input wire logic [ocps_pkg::DATA_W-1:0]    i_wdata,
  input wire logic                           i_wr,
  input wire logic                           i_rd,
  input wire logic [ocps_pkg::DATA_W-1:0]    o_rdata,
  input wire ocps_pkg::ocps_stage_type       o_stage,
  input wire logic                           o_irq
);
  logic [15:0] thr_q, m01, mx;
  logic [2:0]  mode_q, mask_q;
  logic [1:0]  code_now;
  logic        above, below, band, on, rd_cond;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      thr_q  <= THRESH_RST;
      mode_q <= 3'h1;
      mask_q <= MASK_RST;
    end else if (i_wr) begin
      if (i_addr == OFS_THRESH) thr_q <= i_wdata[15:0];
      if (i_addr == OFS_IRQ_MASK) mask_q <= i_wdata[2:0];
      if (i_addr == OFS_CTRL && i_wdata[2:0] inside {[3'h1:3'h5]}) mode_q <= i_wdata[2:0];
    end
  end
  always_comb begin
    band = 1'b1;
    for (int k = 0; k < 3; k++) begin
      band = band && i_phase.mag[k] <= thr_q
             && 32'(i_phase.mag[k]) * 32'h64 >= 32'(thr_q) * 32'h61;
    end
  end
  assign m01      = (i_phase.mag[1] > i_phase.mag[0]) ? i_phase.mag[1] : i_phase.mag[0];
  assign mx       = (i_phase.mag[2] > m01) ? i_phase.mag[2] : m01;
  assign above    = mx > thr_q;
  assign below    = 32'(mx) * 32'h64 < 32'(thr_q) * 32'h61;
  assign on       = mode_q == 3'h1 || mode_q == 3'h3;
  assign rd_cond  = i_rd && i_addr == OFS_COND;
  // blocked outranks trip, as the stage encodes it
  assign code_now = o_stage.blocked ? 2'h3 : o_stage.trip ? 2'h2 : o_stage.start ? 2'h1 : 2'h0;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_rise_start: assert property (
    (above && !i_phase_overcurrent_block && on)[*5] |-> o_stage.start)
    else $error("no start with a phase above threshold");
  a_release_low: assert property (below[*5] |-> !o_stage.start && !o_stage.trip)
    else $error("start held below release level");
  a_band_hold: assert property (
    (band && on && !i_phase_overcurrent_block)[*5] |-> $stable(o_stage.start))
    else $error("start changed inside hysteresis band");
  a_block_start: assert property (i_phase_overcurrent_block[*4] |-> !o_stage.start)
    else $error("start while blocked");
  a_block_flag: assert property (
    (i_phase_overcurrent_block && above && mode_q != 3'h5)[*5] |-> o_stage.blocked)
    else $error("blocked flag missing");
  a_off_quiet: assert property ((mode_q == 3'h5)[*5] |-> o_stage == 3'b000)
    else $error("stage active in off mode");
  a_cond_code: assert property (rd_cond |=> o_rdata[1:0] == $past(code_now))
    else $error("overall code differs from stage outputs");
  a_phase_code: assert property (
    rd_cond |=> o_rdata[7:4] <= 4'he && (o_rdata[1:0] != 2'h0 || o_rdata[7:4] == 4'h0))
    else $error("phase code out of range");
  a_behav_mode: assert property (rd_cond |=> o_rdata[10:8] == $past(mode_q))
    else $error("behaviour differs from configured mode");
  a_irq_masked: assert property (mask_q == 3'h0 |=> !o_irq)
    else $error("interrupt with all sources masked");
  a_rdata_hold: assert property (!i_rd |=> $stable(o_rdata))
    else $error("read data moved without a read");
  c_start: cover property ($rose(o_stage.start));
  c_trip: cover property ($rose(o_stage.trip));
  c_blocked: cover property ($rose(o_stage.blocked));
  c_irq: cover property ($rose(o_irq));
endmodule : ocps_stage_monitor

bind ocps_stage ocps_stage_monitor #(.TICKS(TICKS)) u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_phase(i_phase), .i_phase_overcurrent_block(i_phase_overcurrent_block), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_stage(o_stage),
  .o_irq(o_irq));

/* bench/ocps_meas_model.sv */
// measurement source: phase magnitudes and the blocking input
// assumes the bench sets targets; they reach the stage one edge later
`timescale 1ns/10ps
module ocps_meas_model
  import ocps_pkg::*;
(
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  input  wire ocps_pkg::ocps_phase_mag_type i_target,
  input  wire logic                         i_block_req,
  output ocps_pkg::ocps_phase_mag_type      o_phase,
  output logic                              o_block
);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_phase <= '0;
      o_block <= 1'b0;
    end else begin
      o_phase <= i_target;
      o_block <= i_block_req;
    end
  end
endmodule : ocps_meas_model

/* bench/ocps_stage_bench.sv */
// self-checking bench for the overcurrent pick-up stage
// assumes the measurement model feeds the stage one edge after each change
`timescale 1ns/10ps
module ocps_stage_bench;
  import ocps_pkg::*;
  logic               i_clk, i_rst_n, i_wr, i_rd, blk_req, blk, o_irq, rd_q;
  logic [ADDR_W-1:0]  i_addr;
  logic [DATA_W-1:0]  i_wdata, o_rdata, e, exp_q[$], msk_q[$];
  ocps_phase_mag_type tgt, i_phase;
  ocps_stage_type     o_stage;
  logic [15:0]        v;
  logic [3:0]         pc, st_code[8];
  int                 n_fail, n_compared, seed;
  ocps_meas_model u_src (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_target(tgt),
    .i_block_req(blk_req), .o_phase(i_phase), .o_block(blk));
  ocps_stage #(.TICKS(10)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_phase(i_phase),
    .i_phase_overcurrent_block(blk), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_stage(o_stage), .o_irq(o_irq));
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
    n_compared++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge i_clk);
    exp_q.push_back(d);
    msk_q.push_back(m);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask : rd
  task automatic set3(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge i_clk);
    tgt.mag[0] <= a;
    tgt.mag[1] <= b;
    tgt.mag[2] <= c;
    repeat (12) @(posedge i_clk);
  endtask : set3
  // read data stands in the cycle after the strobe
  always @(posedge i_clk) rd_q <= i_rd;
  always @(negedge i_clk) begin
    if (rd_q) check(o_rdata & msk_q.pop_front(), exp_q.pop_front());
  end
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    #150000;
    n_fail++;
    test_done();
  end
  initial begin
    st_code = '{4'h0, 4'h1, 4'h2, 4'h7, 4'h3, 4'h9, 4'h8, 4'ha};
    seed = 30483;
    {i_rst_n, i_wr, i_rd, blk_req, i_addr, i_wdata, tgt} = '0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(OFS_CTRL, 32'h1, '1);
    rd(OFS_THRESH, 32'h78, '1);
    rd(OFS_DELAY, 32'h14, '1);
    rd(OFS_IRQ_MASK, 32'h0, '1);
    rd(8'h24, 32'h0, '1);
    for (int t = 0; t < 2; t++) begin
      wr(OFS_DELAY, t ? 32'h0 : 32'h14);
      for (int m = 1; m < 8; m++) begin
        v  = 16'h79 + 16'({$random(seed)} % 200);
        pc = t ? st_code[m] + (st_code[m] < 4 ? 4'h3 : 4'h4) : st_code[m];
        set3(m[0] ? v : 16'h0, m[1] ? v : 16'h0, m[2] ? v : 16'h0);
        rd(OFS_COND, {24'h0, pc, 2'h0, t ? 2'h2 : 2'h1}, 32'hffff_f8ff);
        rd(OFS_EXP_TIME, t ? 32'h0 : 32'h14, '1);
        // one 5 ms step has elapsed when the remaining time is read
        rd(OFS_REMAIN, t ? 32'h0 : 32'h13, '1);
        check({29'h0, o_stage}, t ? 32'h6 : 32'h4);
        set3(16'h0, 16'h0, 16'h0);
        rd(OFS_COND, 32'h0, 32'hff);
      end
    end
    wr(OFS_DELAY, 32'h14);
    set3(16'h79, 16'h79, 16'h79);
    check({29'h0, o_stage}, 32'h4);
    set3(16'h75, 16'h75, 16'h75);
    check({29'h0, o_stage}, 32'h4);
    set3(16'h74, 16'h74, 16'h74);
    check({29'h0, o_stage}, 32'h0);
    set3(16'h76, 16'h76, 16'h76);
    check({29'h0, o_stage}, 32'h0);
    set3(16'h78, 16'h0, 16'h0);
    check({29'h0, o_stage}, 32'h0);
    wr(OFS_THRESH, 32'hc8);
    set3(16'h96, 16'h96, 16'hc9);
    rd(OFS_COND, 32'h31, 32'hf3);
    for (int k = 0; k < 3; k++) begin
      v = 16'hc8 + 16'({$random(seed)} % 5000);
      set3(16'h0, v, 16'h0);
      repeat (70) @(posedge i_clk);
      rd(OFS_RATIO, 32'(v) * 32'h64 / 32'hc8, '1);
    end
    wr(OFS_CTRL, 32'h9);
    // ratio and inverse-time dividers run in series, two passes each
    set3(16'h190, 16'h0, 16'h0);
    repeat (150) @(posedge i_clk);
    rd(OFS_EXP_TIME, 32'ha, '1);
    set3(16'h0, 16'h0, 16'h320);
    repeat (150) @(posedge i_clk);
    rd(OFS_EXP_TIME, 32'h5, '1);
    set3(16'h0, 16'h0, 16'h0);
    wr(OFS_DELAY, 32'hffff);
    set3(16'h190, 16'h0, 16'h0);
    for (int md = 1; md < 6; md++) begin
      wr(OFS_CTRL, 32'(md));
      repeat (12) @(posedge i_clk);
      e = md == 5 ? 32'h0 : (md == 2 || md == 4) ? 32'h3 : 32'h1;
      rd(OFS_COND, e | 32'(md) << 8, 32'h703);
    end
    wr(OFS_CTRL, 32'h0);
    rd(OFS_COND, 32'h500, 32'h700);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_MASK, 32'h4);
    @(posedge i_clk);
    blk_req <= 1'b1;
    repeat (12) @(posedge i_clk);
    check({29'h0, o_stage}, 32'h1);
    check({31'h0, o_irq}, 32'h1);
    rd(OFS_COND, 32'h3, 32'h3);
    rd(OFS_IRQ_STAT, 32'h4, 32'h4);
    blk_req <= 1'b0;
    repeat (12) @(posedge i_clk);
    check({29'h0, o_stage}, 32'h4);
    wr(OFS_IRQ_STAT, 32'h4);
    repeat (3) @(posedge i_clk);
    check({31'h0, o_irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (3) @(posedge i_clk);
    check({31'h0, o_irq}, 32'h0);
    repeat (4) @(posedge i_clk);
    test_done();
  end
endmodule : ocps_stage_bench
